//--- core/tfr_history.sv
// Trip history store: present entry with snapshot and two older codes
`timescale 1ns/1ps
`include "tfr_map.svh"

module tfr_history
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic push,
   input wire logic clear,
   input wire tfr_pkg::tfr_entry_t entry,
   output tfr_pkg::tfr_entry_t present,
   output logic [7:0] prev1_code,
   output logic [7:0] prev2_code
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      tfr_pkg::tfr_entry_t now;
      logic [7:0] p1;
      logic [7:0] p2;
   } tfr_hist_state_t;

   tfr_hist_state_t st;
   tfr_hist_state_t next_st;

   // New trip shifts history; a push beats a clear in the same cycle
   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.p2 = st.p1;
         next_st.p1 = st.now.code;
         next_st.now = entry;
      end
      else if (clear)
      begin
         next_st.now = '{`TFR_RST_CODE, `TFR_RST_DATA, `TFR_RST_DATA, `TFR_RST_DATA};
         next_st.p1 = `TFR_RST_CODE;
         next_st.p2 = `TFR_RST_CODE;
      end
   end

   // Register, synchronous reset
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         st <= '{'{`TFR_RST_CODE, `TFR_RST_DATA, `TFR_RST_DATA, `TFR_RST_DATA},
                 `TFR_RST_CODE, `TFR_RST_CODE};
      else
         st <= next_st;
   end

   // Read data straight from the store
   assign present = st.now;
   assign prev1_code = st.p1;
   assign prev2_code = st.p2;

endmodule // tfr_history

//--- core/tfr_map.svh
// Constants for the trip fault recorder: codes, timing and reset values
`ifndef TFR_MAP_SVH
`define TFR_MAP_SVH

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define TFR_CLOCK_HZ 10000000
`define TFR_INPUT_OV_HOLDOFF_S 100

// ---------------------------------------------
// Error codes, shown as two decimal digits
// ---------------------------------------------
`define TFR_CODE_NONE 8'h00
`define TFR_CODE_OC_CONST 8'h01
`define TFR_CODE_OC_DECEL 8'h02
`define TFR_CODE_OC_ACCEL 8'h03
`define TFR_CODE_OC_OTHER 8'h04
`define TFR_CODE_OVERLOAD 8'h05
`define TFR_CODE_BRAKE 8'h06
`define TFR_CODE_BUS_OVER 8'h07
`define TFR_CODE_NVM 8'h08
`define TFR_CODE_BUS_UNDER 8'h09
`define TFR_CODE_SENSOR 8'h10
`define TFR_CODE_CPU 8'h11
`define TFR_CODE_EXTERNAL 8'h12
`define TFR_CODE_UNATTENDED 8'h13
`define TFR_CODE_GROUND 8'h14
`define TFR_CODE_INPUT_OV 8'h15
`define TFR_CODE_MODULE_HOT 8'h21
`define TFR_CODE_CPU_ALT 8'h22
`define TFR_CODE_THERMISTOR 8'h35

// ---------------------------------------------
// Motion phase encoding and history clear value
// ---------------------------------------------
`define TFR_PHASE_CONST 2'h0
`define TFR_PHASE_DECEL 2'h1
`define TFR_PHASE_ACCEL 2'h2
`define TFR_HIST_CLEAR_SEL 2'h0

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define TFR_RST_CODE 8'h00
`define TFR_RST_DATA 16'h0000
`define TFR_RST_COUNT 30'h0

`endif

//--- core/tfr_pkg.sv
// Types shared by the trip fault recorder files
package tfr_pkg;

   // Operating states, one-hot
   typedef enum logic [4:0] {
      TFR_PWRUP = 5'h01,
      TFR_STOP = 5'h02,
      TFR_RUN = 5'h04,
      TFR_UNDERV = 5'h08,
      TFR_TRIP = 5'h10
   } tfr_state_t;

   // One history entry with its operating snapshot
   typedef struct packed {
      logic [7:0] code;
      logic [15:0] freq;
      logic [15:0] current;
      logic [15:0] bus;
   } tfr_entry_t;

endpackage

//--- core/tfr_recorder.sv
// Trip fault recorder: fault capture, drive shutoff, codes and history
`timescale 1ns/1ps
`include "tfr_map.svh"

module tfr_recorder
#(
   parameter int unsigned INPUT_OV_HOLDOFF_CYCLES =
      `TFR_INPUT_OV_HOLDOFF_S * `TFR_CLOCK_HZ
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic oc_fault,
   input wire logic [1:0] oc_phase,
   input wire logic overload_fault,
   input wire logic brake_overuse,
   input wire logic bus_over_voltage,
   input wire logic nvm_fault,
   input wire logic bus_under_voltage,
   input wire logic current_sensor_fault,
   input wire logic cpu_fault,
   input wire logic cpu_alt_fault,
   input wire logic external_trip_input,
   input wire logic thermistor_fault,
   input wire logic ground_fault,
   input wire logic input_over_voltage,
   input wire logic module_overtemp,
   input wire logic low_input_voltage,
   input wire logic restart_failed,
   input wire logic run_command,
   input wire logic unattended_start_guard,
   input wire logic reset_control_input,
   input wire logic stop_reset_key,
   input wire logic [1:0] hist_clear_sel,
   input wire logic hist_clear_store,
   input wire logic nv_reset_mark_in,
   input wire logic [15:0] snap_freq,
   input wire logic [15:0] snap_current,
   input wire logic [15:0] snap_bus,
   output logic drive_enable,
   output logic tripped,
   output logic running,
   output logic uv_indication,
   output logic [7:0] display_code,
   output logic nv_reset_mark,
   output logic [7:0] mon_code,
   output logic [15:0] mon_freq,
   output logic [15:0] mon_current,
   output logic [15:0] mon_bus,
   output logic [7:0] mon_prev1,
   output logic [7:0] mon_prev2
);

   // ---------------------------------------------
   // Constants and types
   // ---------------------------------------------
   // Thirty bits cover the full hold-off at the system clock; a
   // shorter count may be passed in for simulation
   localparam logic [29:0] OV_LAST = 30'(INPUT_OV_HOLDOFF_CYCLES - 1);

   // Whole state of the block in one record; trip and run copy the
   // state so that those two outputs leave straight from a flip-flop
   typedef struct packed {
      tfr_pkg::tfr_state_t state;
      logic drive;
      logic uv;
      logic [7:0] disp;
      logic run_q;
      logic rst_q;
      logic was_run;
      logic [29:0] ov_cnt;
      logic ov_armed;
      logic nv_mark;
      logic trip; // Copy of the trip state for the output
      logic run; // Copy of the run state for the output
   } tfr_main_state_t;

   // Registered state, its next value and the decode between them
   tfr_main_state_t st;
   tfr_main_state_t next_st;
   logic fault_hit;
   logic [7:0] fault_code;
   logic push;
   logic [7:0] push_code;
   logic hist_clear;
   logic clear_req;
   logic run_rise;
   tfr_pkg::tfr_entry_t entry;
   tfr_pkg::tfr_entry_t present;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------

   // Over-current code from the motion phase
   // Phase three and anything unknown count as other conditions
   function automatic logic [7:0] oc_code(input logic [1:0] phase);
      logic [7:0] c;
      c = `TFR_CODE_OC_OTHER;
      if (phase == `TFR_PHASE_CONST)
         c = `TFR_CODE_OC_CONST;
      else if (phase == `TFR_PHASE_DECEL)
         c = `TFR_CODE_OC_DECEL;
      else if (phase == `TFR_PHASE_ACCEL)
         c = `TFR_CODE_OC_ACCEL;
      return c;
   endfunction

   // Power-up checks run in one cycle only, the first after reset
   function automatic logic is_powerup(input tfr_pkg::tfr_state_t s);
      return s == tfr_pkg::TFR_PWRUP;
   endfunction

   // ---------------------------------------------
   // Fault priority
   // ---------------------------------------------

   // Only one code can be shown, so faults that threaten the power
   // stage outrank the supervisory ones
   // The power-up checks are gated by the state, so a ground fault or
   // a stale run level seen later never trips on its own
   always_comb
   begin
      fault_hit = 1'b1;
      fault_code = `TFR_CODE_NONE;
      if (ground_fault && is_powerup(st.state))
         fault_code = `TFR_CODE_GROUND;
      else if (oc_fault)
         fault_code = oc_code(oc_phase);
      else if (current_sensor_fault)
         fault_code = `TFR_CODE_SENSOR;
      else if (module_overtemp)
         fault_code = `TFR_CODE_MODULE_HOT;
      else if (bus_over_voltage)
         fault_code = `TFR_CODE_BUS_OVER;
      else if (bus_under_voltage)
         fault_code = `TFR_CODE_BUS_UNDER;
      else if (input_over_voltage && st.ov_armed)
         fault_code = `TFR_CODE_INPUT_OV;
      else if (cpu_fault)
         fault_code = `TFR_CODE_CPU;
      else if (cpu_alt_fault)
         fault_code = `TFR_CODE_CPU_ALT;
      else if (nvm_fault)
         fault_code = `TFR_CODE_NVM;
      else if (is_powerup(st.state) && nv_reset_mark_in)
         fault_code = `TFR_CODE_NVM;
      else if (brake_overuse)
         fault_code = `TFR_CODE_BRAKE;
      else if (overload_fault)
         fault_code = `TFR_CODE_OVERLOAD;
      else if (thermistor_fault)
         fault_code = `TFR_CODE_THERMISTOR;
      else if (external_trip_input)
         fault_code = `TFR_CODE_EXTERNAL;
      else if (is_powerup(st.state) && unattended_start_guard
               && run_command)
         fault_code = `TFR_CODE_UNATTENDED;
      else
         fault_hit = 1'b0;
   end

   // ---------------------------------------------
   // Edges and requests
   // ---------------------------------------------

   // Reset input clears on its rising edge only, so a held level
   // cannot keep clearing trips that arrive afterwards
   assign clear_req = stop_reset_key || (reset_control_input && !st.rst_q);
   // From stop, run starts on an edge of the command, never on a held level
   assign run_rise = run_command && !st.run_q;
   // History is erased only by a store strobe with the clear selection
   assign hist_clear = hist_clear_store && hist_clear_sel == `TFR_HIST_CLEAR_SEL;
   // The snapshot is taken from live data in the cycle of the trip
   assign entry = '{push_code, snap_freq, snap_current, snap_bus};

   // ---------------------------------------------
   // Operating state
   // ---------------------------------------------
   always_comb
   begin
      next_st = st;
      push = 1'b0;
      push_code = fault_code;
      // Delayed copies for edge detection and the outside reset mark
      next_st.run_q = run_command;
      next_st.rst_q = reset_control_input;
      next_st.nv_mark = reset_control_input;
      // Input over-voltage is ignored until the hold-off has run out
      // Once armed the counter stops, so it can never wrap
      if (!st.ov_armed)
      begin
         if (st.ov_cnt == OV_LAST)
            next_st.ov_armed = 1'b1;
         else
            next_st.ov_cnt = st.ov_cnt + 30'h1;
      end
      // Moves between stop, run and under-voltage; a trip overrides below
      case (st.state)
         tfr_pkg::TFR_PWRUP:
         begin
            // One cycle for the power-up checks, then stop or trip
            next_st.state = tfr_pkg::TFR_STOP;
         end
         tfr_pkg::TFR_STOP:
         begin
            // Low supply is looked at before a run request
            if (low_input_voltage)
            begin
               next_st.state = tfr_pkg::TFR_UNDERV;
               next_st.was_run = 1'b0;
            end
            else if (run_rise)
               next_st.state = tfr_pkg::TFR_RUN;
         end
         tfr_pkg::TFR_RUN:
         begin
            // The key or a dropped command stops the drive
            if (low_input_voltage)
            begin
               next_st.state = tfr_pkg::TFR_UNDERV;
               next_st.was_run = 1'b1;
            end
            else if (stop_reset_key || !run_command)
               next_st.state = tfr_pkg::TFR_STOP;
         end
         tfr_pkg::TFR_UNDERV:
         begin
            // Restart is tried when supply returns; only a failed
            // restart is recorded as a trip
            if (restart_failed)
            begin
               push = 1'b1;
               push_code = `TFR_CODE_BUS_UNDER;
            end
            else if (!low_input_voltage)
               next_st.state = st.was_run ? tfr_pkg::TFR_RUN : tfr_pkg::TFR_STOP;
         end
         tfr_pkg::TFR_TRIP:
         begin
            // Run is refused here; only a clear leaves the trip
            if (clear_req)
               next_st.state = tfr_pkg::TFR_STOP;
         end
         default:
         begin
            // Unused codes fall back to a safe stopped state
            next_st.state = tfr_pkg::TFR_STOP;
         end
      endcase
      // A fault trips from any state; one arriving with a clear wins
      if (fault_hit && (st.state != tfr_pkg::TFR_TRIP || clear_req))
         push = 1'b1;
      // Display follows the trip and is blanked once it is cleared
      if (push)
      begin
         next_st.state = tfr_pkg::TFR_TRIP;
         next_st.disp = push_code;
      end
      else if (next_st.state != tfr_pkg::TFR_TRIP)
         next_st.disp = `TFR_CODE_NONE;
      next_st.drive = next_st.state == tfr_pkg::TFR_RUN;
      next_st.uv = next_st.state == tfr_pkg::TFR_UNDERV;
      next_st.trip = next_st.state == tfr_pkg::TFR_TRIP;
      next_st.run = next_st.state == tfr_pkg::TFR_RUN;
   end

   // Register, synchronous reset; every field is named so that a new
   // field without a reset value stands out
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st.state <= tfr_pkg::TFR_PWRUP;
         st.drive <= 1'b0;
         st.uv <= 1'b0;
         st.disp <= `TFR_RST_CODE;
         st.run_q <= 1'b0;
         st.rst_q <= 1'b0;
         st.was_run <= 1'b0;
         st.ov_cnt <= `TFR_RST_COUNT;
         st.ov_armed <= 1'b0;
         st.nv_mark <= 1'b0;
         st.trip <= 1'b0;
         st.run <= 1'b0;
      end
      else
         st <= next_st;
   end

   // ---------------------------------------------
   // History store
   // ---------------------------------------------
   // Push and clear are decoded here; the store keeps the entries and
   // gives its outputs from its own registers
   tfr_history u_history
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .push(push),
      .clear(hist_clear),
      .entry(entry),
      .present(present),
      .prev1_code(mon_prev1),
      .prev2_code(mon_prev2)
   );

   // ---------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------
   assign drive_enable = st.drive;
   assign tripped = st.trip;
   assign running = st.run;
   assign uv_indication = st.uv;
   assign display_code = st.disp;
   assign nv_reset_mark = st.nv_mark;
   // Monitor outputs come from the history registers inside the store
   assign mon_code = present.code;
   assign mon_freq = present.freq;
   assign mon_current = present.current;
   assign mon_bus = present.bus;

endmodule // tfr_recorder

//--- verification/testbench.sv
// Self-checking testbench for the trip fault recorder
`timescale 1ns/1ps

module testbench;
   localparam int unsigned HOLDOFF = 20;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [12:0] flt = 13'h0;
   logic [1:0] oc_phase = 2'h0;
   logic low_input_voltage = 1'b0;
   logic run_command = 1'b0;
   logic unattended_start_guard = 1'b0;
   logic reset_control_input = 1'b0;
   logic ground_fault = 1'b0;
   logic [1:0] hist_clear_sel = 2'h1;
   logic hist_clear_store = 1'b0;
   logic nv_reset_mark_in = 1'b0;
   logic [15:0] snap_freq = 16'h0;
   logic [15:0] snap_bus = 16'h0;
   logic press_req = 1'b0;
   logic fail_req = 1'b0;
   logic stop_reset_key, restart_failed, drive_enable, tripped, running;
   logic uv_indication, nv_reset_mark;
   logic [7:0] display_code, mon_code, mon_prev1, mon_prev2, p0, p1;
   logic [15:0] mon_freq, mon_current, mon_bus;
   int failures = 0;
   int checks = 0;
   int n, k;
   logic [7:0] codes [15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h09, 8'h10, 8'h11, 8'h22, 8'h12, 8'h35, 8'h21};

   always #50 clock = ~clock;

   tfr_recorder #(.INPUT_OV_HOLDOFF_CYCLES(HOLDOFF)) i_tfr_recorder (
      .clock(clock), .sys_rst(sys_rst), .oc_fault(flt[0]), .oc_phase(oc_phase),
      .overload_fault(flt[1]), .brake_overuse(flt[2]), .bus_over_voltage(flt[3]),
      .nvm_fault(flt[4]), .bus_under_voltage(flt[5]), .current_sensor_fault(flt[6]),
      .cpu_fault(flt[7]), .cpu_alt_fault(flt[8]), .external_trip_input(flt[9]),
      .thermistor_fault(flt[10]), .module_overtemp(flt[11]), .input_over_voltage(flt[12]),
      .ground_fault(ground_fault), .low_input_voltage(low_input_voltage),
      .restart_failed(restart_failed), .run_command(run_command),
      .unattended_start_guard(unattended_start_guard),
      .reset_control_input(reset_control_input), .stop_reset_key(stop_reset_key),
      .hist_clear_sel(hist_clear_sel), .hist_clear_store(hist_clear_store),
      .nv_reset_mark_in(nv_reset_mark_in), .snap_freq(snap_freq),
      .snap_current(~snap_freq), .snap_bus(snap_bus), .drive_enable(drive_enable),
      .tripped(tripped), .running(running), .uv_indication(uv_indication),
      .display_code(display_code), .nv_reset_mark(nv_reset_mark), .mon_code(mon_code),
      .mon_freq(mon_freq), .mon_current(mon_current), .mon_bus(mon_bus),
      .mon_prev1(mon_prev1),
      .mon_prev2(mon_prev2));

   tfr_partner i_tfr_partner (.clock(clock), .press_req(press_req), .fail_req(fail_req),
      .uv_indication(uv_indication), .stop_reset_key(stop_reset_key),
      .restart_failed(restart_failed));

   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Let c edges pass, then look at settled outputs
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic do_reset;
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      p0 = 8'h00;
      p1 = 8'h00;
   endtask

   task automatic wait_trip;
      for (n = 0; n < 30 && tripped !== 1'b1; n++) @(negedge clock);
   endtask

   task automatic expect_trip(input logic [7:0] c);
      chk("tripped", 16'h1, {15'h0, tripped});
      chk("drive", 16'h0, {15'h0, drive_enable});
      chk("display", {8'h0, c}, {8'h0, display_code});
      chk("mon_code", {8'h0, c}, {8'h0, mon_code});
      chk("prev1", {8'h0, p0}, {8'h0, mon_prev1});
      chk("prev2", {8'h0, p1}, {8'h0, mon_prev2});
      p1 = p0;
      p0 = c;
   endtask

   // Press goes through the keypad model, which holds the key itself
   task automatic clear_key;
      @(posedge clock);
      press_req <= 1'b1;
      @(posedge clock);
      press_req <= 1'b0;
      tick(4);
      chk("cleared", 16'h0, {15'h0, tripped});
   endtask

   task automatic start_run;
      @(posedge clock);
      run_command <= 1'b1;
      for (n = 0; n < 4 && running !== 1'b1; n++) @(negedge clock);
      chk("drive on", 16'h1, {15'h0, drive_enable});
   endtask

   task automatic hclr(input logic [1:0] sel);
      @(posedge clock);
      hist_clear_sel <= sel;
      hist_clear_store <= 1'b1;
      @(posedge clock);
      hist_clear_store <= 1'b0;
      tick(1);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_ov;
      @(posedge clock);
      flt <= 13'h1000;
      do_reset;
      tick(HOLDOFF - 6);
      chk("ov early", 16'h0, {15'h0, tripped});
      wait_trip;
      expect_trip(8'h15);
      @(posedge clock);
      flt <= 13'h0;
      clear_key;
      $display("t_ov done");
   endtask

   task automatic t_powerup;
      for (k = 0; k < 3; k++)
      begin
         @(posedge clock);
         ground_fault <= (k == 0);
         run_command <= (k == 1);
         unattended_start_guard <= (k == 1);
         nv_reset_mark_in <= (k == 2);
         do_reset;
         wait_trip;
         expect_trip(k == 0 ? 8'h14 : k == 1 ? 8'h13 : 8'h08);
         @(posedge clock);
         ground_fault <= 1'b0;
         nv_reset_mark_in <= 1'b0;
         reset_control_input <= (k == 2);
         if (k == 2)
         begin
            tick(1);
            chk("mark", 16'h1, {15'h0, nv_reset_mark});
            chk("rs clear", 16'h0, {15'h0, tripped});
            @(posedge clock);
            reset_control_input <= 1'b0;
         end
         else
            clear_key;
         chk("no run", 16'h0, {15'h0, running});
      end
      @(posedge clock);
      run_command <= 1'b0;
      unattended_start_guard <= 1'b0;
      $display("t_powerup done");
   endtask

   // Each fault source but input over-voltage and ground fault, over-current once per phase; even entries trip in run, odd ones in stop
   task automatic t_faults;
      for (k = 0; k < 15; k++)
      begin
         if (k % 2 == 0)
            start_run;
         @(posedge clock);
         oc_phase <= k[1:0];
         snap_freq <= 16'h0100 + k[15:0];
         snap_bus <= 16'h0200 + k[15:0];
         flt[k < 4 ? 0 : k - 3] <= 1'b1;
         tick(1);
         expect_trip(codes[k]);
         chk("freq", 16'h0100 + k[15:0], mon_freq);
         chk("current", ~(16'h0100 + k[15:0]), mon_current);
         @(posedge clock);
         flt <= 13'h0;
         run_command <= 1'b0;
         clear_key;
      end
      $display("t_faults done");
   endtask

   task automatic t_uv;
      start_run;
      @(posedge clock);
      low_input_voltage <= 1'b1;
      tick(1);
      chk("uv", 16'h8001, {uv_indication, drive_enable, tripped, 13'h1});
      @(posedge clock);
      low_input_voltage <= 1'b0;
      tick(2);
      chk("rerun", 16'h1, {15'h0, running});
      @(posedge clock);
      low_input_voltage <= 1'b1;
      fail_req <= 1'b1;
      wait_trip;
      expect_trip(8'h09);
      @(posedge clock);
      low_input_voltage <= 1'b0;
      fail_req <= 1'b0;
      run_command <= 1'b0;
      clear_key;
      $display("t_uv done");
   endtask

   task automatic t_hist;
      hclr(2'h1);
      chk("kept", {8'h0, p0}, {8'h0, mon_code});
      hclr(2'h0);
      chk("erased", 16'h0, {mon_code, mon_prev1 | mon_prev2});
      $display("t_hist done");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ---------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      t_ov;
      t_powerup;
      t_faults;
      t_uv;
      t_hist;
      tally_and_finish;
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge clock);
      failures++;
      tally_and_finish;
   end
endmodule // testbench

//--- verification/tfr_partner.sv
// Model of the operator keypad and the motor power stage
`timescale 1ns/1ps

module tfr_partner
#(
   parameter int KEY_CYCLES = 2,
   parameter int RESTART_CYCLES = 3
)
(
   input wire logic clock,
   input wire logic press_req,
   input wire logic fail_req,
   input wire logic uv_indication,
   output logic stop_reset_key,
   output logic restart_failed
);
   int kc = 0;
   int rc = 0;
   initial restart_failed = 1'b0;

   // Key held for a whole press; restart fails only when told to
   always @(posedge clock)
   begin
      if (press_req)
         kc <= KEY_CYCLES;
      else if (kc > 0)
         kc <= kc - 1;
      rc <= (uv_indication && fail_req) ? rc + 1 : 0;
      restart_failed <= uv_indication && fail_req && rc == RESTART_CYCLES;
   end
   assign stop_reset_key = kc > 0;
endmodule // tfr_partner

//--- verification/tfr_recorder_properties.sv
// Concurrent checks on the trip fault recorder ports
`timescale 1ns/1ps

module tfr_recorder_checker
#(
   parameter int unsigned INPUT_OV_HOLDOFF_CYCLES = 20
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic oc_fault,
   input wire logic [1:0] oc_phase,
   input wire logic reset_control_input,
   input wire logic stop_reset_key,
   input wire logic [1:0] hist_clear_sel,
   input wire logic hist_clear_store,
   input wire logic [15:0] snap_freq,
   input wire logic [15:0] snap_bus,
   input wire logic drive_enable,
   input wire logic tripped,
   input wire logic running,
   input wire logic [7:0] display_code,
   input wire logic [7:0] mon_code,
   input wire logic [15:0] mon_freq,
   input wire logic [15:0] mon_bus,
   input wire logic [7:0] mon_prev1,
   input wire logic [7:0] mon_prev2
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   // Edges since reset release, saturating so long runs never wrap
   logic [31:0] age;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         age <= 32'h0;
      else if (age != 32'hffffffff)
         age <= age + 32'h1;
   end

   // ---------------------------------------------
   // Trip behaviour
   // ---------------------------------------------
   property p_off;
      tripped |-> !drive_enable && !running;
   endproperty
   a_off: assert property (p_off) else $error("drive on while tripped");
   property p_code;
      $rose(tripped) |-> display_code != 8'h00 && display_code == mon_code;
   endproperty
   a_code: assert property (p_code) else $error("no code on trip");
   property p_shift;
      $rose(tripped) |-> mon_prev1 == $past(mon_code) && mon_prev2 == $past(mon_prev1);
   endproperty
   a_shift: assert property (p_shift) else $error("history not shifted");
   property p_snap;
      $rose(tripped) |-> mon_freq == $past(snap_freq) && mon_bus == $past(snap_bus);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot not latched");
   property p_clr;
      $fell(tripped) |->
         $past(stop_reset_key) || ($past(reset_control_input) && !$past(reset_control_input, 2));
   endproperty
   a_clr: assert property (p_clr) else $error("trip cleared without cause");
   property p_oc;
      running && oc_fault |=> tripped && display_code == 8'($past(oc_phase)) + 8'h01;
   endproperty
   a_oc: assert property (p_oc) else $error("wrong over-current code");
   property p_hclr;
      hist_clear_store && hist_clear_sel == 2'h0 |=>
         (mon_code | mon_prev1 | mon_prev2) == 8'h00 || mon_prev1 == $past(mon_code);
   endproperty
   a_hclr: assert property (p_hclr) else $error("history not erased");
   // Code 15 may first show one edge after the hold-off count has elapsed
   property p_ovh;
      age <= INPUT_OV_HOLDOFF_CYCLES |-> display_code != 8'h15;
   endproperty
   a_ovh: assert property (p_ovh) else $error("input over-voltage too early");
endmodule // tfr_recorder_checker

bind tfr_recorder tfr_recorder_checker
   #(.INPUT_OV_HOLDOFF_CYCLES(INPUT_OV_HOLDOFF_CYCLES)) i_tfr_recorder_checker (
   .clock(clock), .sys_rst(sys_rst), .oc_fault(oc_fault), .oc_phase(oc_phase),
   .reset_control_input(reset_control_input), .stop_reset_key(stop_reset_key),
   .hist_clear_sel(hist_clear_sel), .hist_clear_store(hist_clear_store),
   .snap_freq(snap_freq), .snap_bus(snap_bus), .drive_enable(drive_enable),
   .tripped(tripped), .running(running), .display_code(display_code),
   .mon_code(mon_code), .mon_freq(mon_freq), .mon_bus(mon_bus),
   .mon_prev1(mon_prev1), .mon_prev2(mon_prev2));
